// file: src/standby_pkg.sv
package standby_pkg;

  // Wishbone register offsets (byte addresses).
  localparam logic [7:0] ctrl_ofs = 8'h00;
  localparam logic [7:0] timer_ofs = 8'h04;
  localparam logic [7:0] halt_ofs = 8'h08;
  localparam logic [7:0] pins_ofs = 8'h0c;
  localparam logic [7:0] status_ofs = 8'h10;

  // Control field positions.
  localparam int port_sense0_in_bit = 0;
  localparam int port_kio_out_bit = 1;
  localparam int port_led_mode_bit = 2;
  localparam int port_s2_release_bit = 3;
  localparam int div2_bit = 8;
  localparam logic [7:0] port_ctrl_reset = 8'h26;

  // Timer layout: nine count bits plus the output-permit bit.
  localparam int timer_w = 10;
  localparam int permit_bit = 9;
  localparam int timer_div_fast = 64;
  localparam int timer_div_slow = 128;

  // Wake wait after a stop-mode release, in oscillator periods.
  localparam int wake_wait_cycles = 256;

  // Halt operand codes, low three bits.
  localparam logic [2:0] op_stop_all = 3'h0;
  localparam logic [2:0] op_stop_all_b = 3'h3;
  localparam logic [2:0] op_stop_k0 = 3'h6;
  localparam logic [2:0] op_halt_timer = 3'h5;
  localparam int op_sense_bit = 3;

  typedef enum logic [2:0] {
    st_run = 3'b000,
    st_halt = 3'b001,
    st_stop_pend = 3'b010,
    st_stop = 3'b011,
    st_wake_wait = 3'b100
  } mode_t;

  // Pin inputs grouped together.
  typedef struct packed {
    logic [3:0] key_input_pins;
    logic [7:0] key_io_pins;
    logic sense_pin_0;
    logic sense_pin_1;
    logic sense_pin_2;
  } pins_t;

endpackage

// file: src/standby_wake_controller.sv
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - Zero load sets infrared output by permit.
// - Stop mode halts oscillator, pins low.
// - Halt pauses cpu, timer keeps running.
// - Standby keeps state; wake flag zero.
// - Stop first clears timer and permit.
// - Entry only by operand with flag zero.
// - Wake exit sets the wake flag.
// - Flag set: no entry, clear unless wake.
// - Wake already true: skip, set flag.
// - Reset restarts at zero, wake continues.
// - Codes 0000/0011 need all key outputs high.
// - Code x110 needs key output zero high.
// - Bit three adds enabled sense pin wake.
// - Code x101 halts until timer zero.
// - Illegal operand or precondition forces reset.
// - Stop wake waits, rechecks, else restops.
// - Timer ticks every 64 or 128 periods.
// - Permit drives indicator low, infrared high.
module standby_wake_controller #(
  parameter int wait_cycles = standby_pkg::wake_wait_cycles
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire standby_pkg::pins_t i_pins,
  input wire logic [7:0] i_key_io_out_level,
  output logic o_ir_tx_out,
  output logic o_indicator_out,
  output logic o_osc_in_pin,
  output logic o_osc_out_pin,
  output logic o_osc_enable,
  output logic o_cpu_run,
  output logic o_internal_reset,
  output logic o_resume_next
);
  import standby_pkg::*;

  mode_t mode;
  mode_t next_mode;
  logic [8:0] port_control_reg;
  logic [timer_w-1:0] timer;
  logic [7:0] prescale;
  logic wake_flag;
  logic [3:0] halt_op;
  logic [15:0] wait_cnt;
  logic ack;
  logic soft_high;
  logic [31:0] rd_word;

  // True when any sense pin is high and set up to release stop mode.
  // Sense pin 1 only counts while its pin is an input, not the indicator.
  function automatic logic sense_hit(input pins_t p, input logic [8:0] ctrl);
    logic s0;
    logic s1;
    logic s2;
    s0 = p.sense_pin_0 && ctrl[port_sense0_in_bit];
    s1 = p.sense_pin_1 && !ctrl[port_led_mode_bit];
    s2 = p.sense_pin_2 && ctrl[port_s2_release_bit];
    return s0 || s1 || s2;
  endfunction

  // Bus decode.
  wire bus_req = i_wb_cyc && i_wb_stb && !ack;
  wire bus_wr = bus_req && i_wb_we && i_wb_sel[0];
  wire wr_ctrl = bus_wr && (i_wb_adr == ctrl_ofs);
  wire wr_timer = bus_wr && (i_wb_adr == timer_ofs);
  wire wr_halt = bus_wr && (i_wb_adr == halt_ofs);
  wire wr_status = bus_wr && (i_wb_adr == status_ofs);

  // Timer loads are accepted while the oscillator runs the cpu or the halt.
  wire timer_load = wr_timer && (mode == st_run || mode == st_halt);
  wire load_zero = (i_wb_dat[permit_bit-1:0] == '0);

  // Timer status and tick enable.
  wire timer_running = (timer[permit_bit-1:0] != 9'h000);
  wire permit = timer[permit_bit];
  wire [7:0] tick_top = port_control_reg[div2_bit] ? 8'(timer_div_slow - 1)
                                                    : 8'(timer_div_fast - 1);
  wire osc_on = (mode != st_stop);
  wire tick = osc_on && (prescale == tick_top);

  // Wake conditions, combinational from pins and timer.
  wire key_wake = |i_pins.key_input_pins;
  wire sense_armed = sense_hit(i_pins, port_control_reg);
  wire sense_wake = halt_op[op_sense_bit] && sense_armed;
  wire stop_wake = key_wake || sense_wake;
  wire timer_wake = !timer_running;

  // Operand decode of the incoming halt request.
  wire [2:0] op_lo = i_wb_dat[2:0];
  wire op_bit3 = i_wb_dat[op_sense_bit];
  wire kio_out = port_control_reg[port_kio_out_bit];
  wire is_halt = (op_lo == op_halt_timer);
  wire is_stop_all = (op_lo == op_stop_all) || (op_lo == op_stop_all_b);
  wire is_stop_k0 = (op_lo == op_stop_k0);
  wire pre_all = kio_out && (i_key_io_out_level == 8'hff);
  wire pre_k0 = kio_out && i_key_io_out_level[0];
  wire pre_ok = is_halt || (is_stop_all && pre_all) || (is_stop_k0 && pre_k0);
  wire req_sense = op_bit3 && sense_armed;
  wire req_wake = is_halt ? timer_wake : (key_wake || req_sense);
  wire req_illegal = (mode == st_run) && wr_halt && !pre_ok;
  wire req_ok = (mode == st_run) && wr_halt && pre_ok;
  wire enter = req_ok && !wake_flag && !req_wake;

  // Mode transitions.
  always_comb begin
    next_mode = mode;
    unique case (mode)
      st_run: begin
        if (enter) begin
          next_mode = is_halt ? st_halt : st_stop_pend;
        end
      end
      st_halt: begin
        if (timer_wake) begin
          next_mode = st_run;
        end
      end
      st_stop_pend: begin
        if (timer == '0) begin
          next_mode = st_stop;
        end
      end
      st_stop: begin
        if (stop_wake) begin
          next_mode = st_wake_wait;
        end
      end
      st_wake_wait: begin
        if (wait_cnt == 16'(wait_cycles - 1)) begin
          next_mode = stop_wake ? st_run : st_stop;
        end
      end
      default: next_mode = st_run;
    endcase
  end

  // A standby mode ending through its own wake condition.
  wire halt_exit = (mode == st_halt) && timer_wake;
  wire stop_exit = (mode == st_wake_wait) && (next_mode == st_run);

  // Mode state and operand capture.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || req_illegal) begin
      mode <= st_run;
      halt_op <= 4'h0;
    end else begin
      mode <= next_mode;
      if (req_ok) begin
        halt_op <= {op_bit3, op_lo};
      end
    end
  end

  // Wait counter for oscillator restart.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || mode != st_wake_wait) begin
      wait_cnt <= 16'h0000;
    end else begin
      wait_cnt <= wait_cnt + 16'h0001;
    end
  end

  // Wake flag: set on wake exit, handled at halt execution.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || req_illegal) begin
      wake_flag <= 1'b0;
    end else if (halt_exit || stop_exit) begin
      wake_flag <= 1'b1;
    end else if (req_ok) begin
      wake_flag <= req_wake;
    end else if (wr_status && i_wb_dat[0]) begin
      wake_flag <= 1'b0;
    end
  end

  // Prescaler: restarts on a load and idles while the count is zero.
  // Idling at zero makes every run last whole timer periods from its load.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || req_illegal || timer_load || tick || timer_wake) begin
      prescale <= 8'h00;
    end else if (osc_on) begin
      prescale <= prescale + 8'h01;
    end
  end

  // Port control register, written only while the cpu runs.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || req_illegal) begin
      port_control_reg <= {1'b0, port_ctrl_reset};
    end else if (wr_ctrl && mode == st_run) begin
      port_control_reg <= i_wb_dat[8:0];
    end
  end

  // Down counter with its output-permit bit; a pending stop empties both.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || req_illegal) begin
      timer <= '0;
    end else if (timer_load) begin
      timer <= i_wb_dat[timer_w-1:0];
    end else if (mode == st_stop_pend) begin
      timer <= '0;
    end else if (tick && timer_running) begin
      timer <= timer - 10'(1);
    end
  end

  // A zero-count load sets the infrared level from the permit bit.
  // The level stands until the next load, so software shapes short pulses.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || req_illegal) begin
      soft_high <= 1'b0;
    end else if (timer_load) begin
      soft_high <= load_zero && i_wb_dat[permit_bit];
    end
  end

  // Outputs: timer drives infrared and indicator.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_ir_tx_out <= 1'b0;
      o_indicator_out <= 1'b1;
    end else begin
      o_ir_tx_out <= permit && (timer_running || soft_high);
      o_indicator_out <= !(permit && timer_running);
    end
  end

  // Read data selection by byte address; unmapped addresses read zero.
  always_comb begin
    unique case (i_wb_adr)
      ctrl_ofs: rd_word = {23'h0, port_control_reg};
      timer_ofs: rd_word = {22'h0, timer};
      halt_ofs: rd_word = {28'h0, halt_op};
      pins_ofs: rd_word = {17'h0, i_pins};
      status_ofs: rd_word = {27'h0, mode, timer_running, wake_flag};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus answer: one ack per request, data registered with it.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      ack <= bus_req;
      o_wb_dat <= rd_word;
    end
  end

  // Status outputs.
  assign o_wb_ack = ack;
  assign o_osc_enable = osc_on;
  assign o_osc_in_pin = 1'b0;
  assign o_osc_out_pin = 1'b0;
  assign o_cpu_run = (mode == st_run);
  assign o_internal_reset = req_illegal;
  assign o_resume_next = halt_exit || stop_exit;
endmodule

// file: sim/swc_monitor.sv
`timescale 1ns/100ps
// Watches the bus answer, oscillator and standby outputs of the controller.
module swc_monitor (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic o_wb_ack,
  input wire logic o_osc_in_pin,
  input wire logic o_osc_out_pin,
  input wire logic o_osc_enable,
  input wire logic o_cpu_run,
  input wire logic o_internal_reset
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // Write request and the run phase that must follow a forced reset.
  sequence wr_s; i_wb_cyc && i_wb_stb && i_wb_we; endsequence
  sequence run2_s; o_cpu_run [*2]; endsequence
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  ack_one_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  osc_pins_low_a: assert property (!o_osc_enable |-> !o_osc_in_pin && !o_osc_out_pin)
    else $error("oscillator pins not low");
  stop_cpu_a: assert property (!o_osc_enable |-> !o_cpu_run)
    else $error("cpu runs without clock");
  wake_wait_a: assert property ($rose(o_osc_enable) |-> !o_cpu_run [*2])
    else $error("no wait after restart");
  entry_cause_a: assert property ($fell(o_cpu_run) |-> $past(i_wb_cyc && i_wb_we))
    else $error("standby entered without halt write");
  bad_op_a: assert property (o_internal_reset |-> wr_s and o_cpu_run)
    else $error("reset outside halt write");
  bad_op_run_a: assert property (o_internal_reset |=> run2_s)
    else $error("standby entered after reset");
endmodule

// file: sim/key_pad_model.sv
`timescale 1ns/100ps
// Key matrix and sense switches; released inputs fall to their pull-down level.
module key_pad_model (
  input wire logic i_core_clk,
  input wire logic [3:0] i_keys,
  input wire logic [2:0] i_sense,
  input wire logic [7:0] i_io_level,
  output standby_pkg::pins_t o_pins
);
  import standby_pkg::*;
  // A press is seen for as long as the bench holds it.
  always_ff @(posedge i_core_clk) begin
    o_pins <= {i_keys, i_io_level, i_sense[0], i_sense[1], i_sense[2]};
  end
endmodule

// file: sim/tb_standby_wake_controller.sv
`timescale 1ns/100ps
module tb_standby_wake_controller;
  import standby_pkg::*;
  logic clk = 0;
  logic srst = 1;
  logic cyc = 0;
  logic we = 0;
  logic seen = 0;
  logic resumed = 0;
  logic [7:0] adr = 0;
  logic [7:0] lvl = 8'hff;
  logic [31:0] wdat = 0;
  logic [31:0] rdat, q;
  logic [3:0] keys = 0;
  logic [2:0] sense = 0;
  logic ack, ir, indicator_out, osc, run, irst, res;
  pins_t pins;
  int n_errors = 0;
  int samples_checked = 0;
  // Device under test with a short wake wait, and the key pad beside it.
  standby_wake_controller #(.wait_cycles(4)) i_dut (.i_core_clk(clk), .i_srst(srst),
    .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack), .i_pins(pins),
    .i_key_io_out_level(lvl), .o_ir_tx_out(ir), .o_indicator_out(indicator_out),
    .o_osc_in_pin(), .o_osc_out_pin(), .o_osc_enable(osc), .o_cpu_run(run),
    .o_internal_reset(irst), .o_resume_next(res));
  key_pad_model i_pad (.i_core_clk(clk), .i_keys(keys), .i_sense(sense),
    .i_io_level(lvl), .o_pins(pins));
  // Clock and sticky records of forced resets and of resumes after a wake.
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (irst) seen <= 1'b1;
  always @(posedge clk) if (res) resumed <= 1'b1;
  task complete_run;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic single bus cycle; read data is taken at the ack edge.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++k < 50);
    q = rdat;
    cyc <= 0;
    if (ack !== 1'b1) begin
      n_errors++;
      complete_run;
    end
  endtask
  // Bounded wait on the oscillator (s=1) or run (s=0) output.
  task wfor(input logic s, input logic v, input int lim);
    int k;
    k = 0;
    while ((s ? osc : run) !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk(s ? osc : run, v);
    if ((s ? osc : run) !== v) complete_run;
  endtask
  task t_reset;
    chk(ir, 0);
    chk(indicator_out, 1);
    wb(0, ctrl_ofs, 0);
    chk(q, 32'h26);
    wb(0, 8'h40, 0);
    chk(q, 0);
    $display("reset test done");
  endtask
  task t_pulse;
    wb(1, timer_ofs, 32'h201);
    repeat (2) @(posedge clk);
    chk({ir, indicator_out}, 2'b10);
    repeat (70) @(posedge clk);
    chk({ir, indicator_out}, 2'b01);
    wb(1, ctrl_ofs, 32'h126);
    wb(1, timer_ofs, 32'h201);
    repeat (100) @(posedge clk);
    chk({ir, indicator_out}, 2'b10);
    repeat (40) @(posedge clk);
    chk({ir, indicator_out}, 2'b01);
    wb(1, ctrl_ofs, 32'h26);
    wb(1, timer_ofs, 32'h200);
    repeat (2) @(posedge clk);
    chk(ir, 1);
    wb(1, timer_ofs, 0);
    repeat (2) @(posedge clk);
    chk(ir, 0);
    $display("pulse test done");
  endtask
  task t_halt;
    resumed = 0;
    wb(1, timer_ofs, 3);
    wb(1, halt_ofs, 5);
    chk({run, osc}, 2'b01);
    wb(0, status_ofs, 0);
    chk(q[0], 0);
    repeat (150) @(posedge clk);
    chk(run, 0);
    wfor(0, 1, 40);
    chk(resumed, 1);
    wb(0, status_ofs, 0);
    chk(q[0], 1);
    wb(1, halt_ofs, 5);
    wb(0, status_ofs, 0);
    chk({run, q[0]}, 2'b11);
    wb(1, status_ofs, 1);
    wb(1, halt_ofs, 5);
    wb(0, status_ofs, 0);
    chk({run, q[0]}, 2'b11);
    wb(1, timer_ofs, 3);
    wb(1, halt_ofs, 5);
    wb(0, status_ofs, 0);
    chk({run, q[0]}, 2'b10);
    $display("halt test done");
  endtask
  task t_bad;
    seen = 0;
    resumed = 0;
    wb(1, halt_ofs, 1);
    chk({seen, run}, 2'b11);
    chk(resumed, 0);
    seen = 0;
    lvl <= 8'h7f;
    wb(1, halt_ofs, 0);
    chk(seen, 1);
    lvl <= 8'hff;
    $display("illegal test done");
  endtask
  task t_stop;
    wb(1, timer_ofs, 32'h205);
    wb(1, halt_ofs, 3);
    wfor(1, 0, 50);
    chk(ir, 0);
    keys <= 4'h1;
    @(posedge clk);
    keys <= 4'h0;
    wfor(1, 1, 10);
    wfor(1, 0, 30);
    resumed = 0;
    keys <= 4'h8;
    wfor(0, 1, 50);
    chk(resumed, 1);
    keys <= 4'h0;
    wb(0, status_ofs, 0);
    chk(q[0], 1);
    wb(1, status_ofs, 1);
    wb(1, ctrl_ofs, 32'h2e);
    lvl <= 8'h01;
    wb(1, halt_ofs, 32'he);
    wfor(1, 0, 50);
    sense <= 3'b100;
    wfor(0, 1, 50);
    sense <= 0;
    $display("stop test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 0;
    t_reset;
    t_pulse;
    t_halt;
    t_bad;
    t_stop;
    complete_run;
  end
endmodule
bind standby_wake_controller swc_monitor i_mon (.i_core_clk, .i_srst, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .o_wb_ack, .o_osc_in_pin, .o_osc_out_pin, .o_osc_enable,
  .o_cpu_run, .o_internal_reset);
